/* core/intc_pkg.sv */
// Constants shared by the two-level interrupt controller and its helpers.
// Assumes a single clock domain and a 32-bit AXI4-Lite register bus.
//
// Summary of operation
// R1 - The normal request to the core is the OR of all 32 normal enabled-status bits.
// R2 - A normal enabled-status bit other than bit 1 is set only while its source signals and is enabled.
// R3 - There is no priority encoder or vector; software reads the status registers.
// R4 - Each raw-signal bit follows its source line regardless of the enable mask.
// R5 - A normal mask bit at one lets the source request, at zero it masks the source.
// R6 - Writing the normal mask only sets bits; zeros written there change nothing.
// R7 - Each one written to the normal clear register clears that normal mask bit.
// R8 - A fast path with raw, enable, clear and status registers works like the normal one.
// R9 - The OR of all fast status bits is the fast request and also source bit 0 of both paths.
// R10 - Writing a one to a fast mask bit clears the same normal mask bit.
// R11 - Writing a one to a normal mask bit clears the same fast mask bit.
// R12 - A source may be disabled in both masks at once.
// R13 - Software control bit 1 drives bit 1 of normal raw and status, unmaskable.
// R14 - Software control bit 2 drives bit 1 of fast raw and status, unmaskable.
// R15 - Writes to read-only registers are ignored and all masks clear at reset.
`default_nettype none

package intc_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;

  localparam logic [31:0] OFS_NORMAL_STATUS = 32'hFFFF0000;
  localparam logic [31:0] OFS_NORMAL_RAW = 32'hFFFF0004;
  localparam logic [31:0] OFS_NORMAL_MASK = 32'hFFFF0008;
  localparam logic [31:0] OFS_NORMAL_CLEAR = 32'hFFFF000C;
  localparam logic [31:0] OFS_SOFT_CTRL = 32'hFFFF0010;
  localparam logic [31:0] OFS_FAST_STATUS = 32'hFFFF0100;
  localparam logic [31:0] OFS_FAST_RAW = 32'hFFFF0104;
  localparam logic [31:0] OFS_FAST_MASK = 32'hFFFF0108;
  localparam logic [31:0] OFS_FAST_CLEAR = 32'hFFFF010C;
  localparam logic [31:0] OFS_EVENT_STATUS = 32'hFFFF0200;
  localparam logic [31:0] OFS_EVENT_MASK = 32'hFFFF0204;

  localparam logic [31:0] RST_MASK = 32'h00000000;
  localparam logic [31:0] RST_SOFT_CTRL = 32'h00000000;
  localparam logic [31:0] RST_STATUS = 32'h00000000;
  localparam logic [1:0] RST_EVENT = 2'h0;

  localparam int unsigned FAST_SRC_BIT = 0;
  localparam int unsigned SOFT_SRC_BIT = 1;
  localparam int unsigned SOFT_NORMAL_BIT = 1;
  localparam int unsigned SOFT_FAST_BIT = 2;
  localparam logic [31:0] SOFT_CTRL_USED = 32'h00000006;

  localparam int unsigned EVT_NORMAL_BIT = 0;
  localparam int unsigned EVT_FAST_BIT = 1;
  localparam int unsigned EVT_W = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

/* core/request_path.sv */
// One interrupt level: raw capture, enabled status and the request line.
// Assumes source lines and masks come from logic on aclk.
`default_nettype none

module request_path #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] src_lines,
  input wire logic [WIDTH-1:0] enable_mask,
  input wire logic [WIDTH-1:0] force_mask,
  output logic [WIDTH-1:0] raw_q,
  output logic [WIDTH-1:0] status_q,
  output logic request_q
);

  logic [WIDTH-1:0] status_d;

  // Unmaskable bits bypass the mask so software sources always reach status
  assign status_d = src_lines & (enable_mask | force_mask); // see R2 see R5 see R13

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_q <= '0;
    end else if (ce) begin
      raw_q <= src_lines; // see R4
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
      request_q <= 1'b0;
    end else if (ce) begin
      status_q <= status_d;
      request_q <= |status_d; // see R1 see R3
    end
  end

endmodule

`default_nettype wire

/* core/event_flags.sv */
// Sticky event flags with write-one-to-clear, a mask and one level interrupt.
// Assumes events are single-cycle pulses on aclk.
`default_nettype none

module event_flags #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] event_pulse,
  input wire logic status_clear_en,
  input wire logic mask_write_en,
  input wire logic [WIDTH-1:0] write_bits,
  output logic [WIDTH-1:0] status_q,
  output logic [WIDTH-1:0] mask_q,
  output logic irq
);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
    end else if (ce) begin
      // A new event in the clearing cycle survives the clear
      status_q <= (status_q & ~(status_clear_en ? write_bits : '0)) | event_pulse;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= '0;
    end else if (ce && mask_write_en) begin
      mask_q <= write_bits;
    end
  end

  assign irq = |(status_q & mask_q);

endmodule

`default_nettype wire

/* core/dual_level_interrupt_controller.sv */
// Two-level interrupt controller with an AXI4-Lite register slave.
// Assumes peripheral lines are synchronous to aclk; reset is synchronous.
`default_nettype none

module dual_level_interrupt_controller #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [intc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [intc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [intc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [intc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [WIDTH-1:0] src_lines,
  output logic normal_request,
  output logic fast_request,
  output logic irq
);

  typedef enum logic [3:0] {
    REG_NONE,
    REG_NORMAL_STATUS,
    REG_NORMAL_RAW,
    REG_NORMAL_MASK,
    REG_NORMAL_CLEAR,
    REG_SOFT_CTRL,
    REG_FAST_STATUS,
    REG_FAST_RAW,
    REG_FAST_MASK,
    REG_FAST_CLEAR,
    REG_EVENT_STATUS,
    REG_EVENT_MASK
  } reg_sel_e;

  // Full word-aligned decode; byte offset bits are ignored
  function automatic reg_sel_e decode(input logic [intc_pkg::ADDR_W-1:0] addr);
    logic [intc_pkg::ADDR_W-1:0] a;
    a = {addr[intc_pkg::ADDR_W-1:2], 2'b00};
    case (a)
      intc_pkg::OFS_NORMAL_STATUS: decode = REG_NORMAL_STATUS;
      intc_pkg::OFS_NORMAL_RAW: decode = REG_NORMAL_RAW;
      intc_pkg::OFS_NORMAL_MASK: decode = REG_NORMAL_MASK;
      intc_pkg::OFS_NORMAL_CLEAR: decode = REG_NORMAL_CLEAR;
      intc_pkg::OFS_SOFT_CTRL: decode = REG_SOFT_CTRL;
      intc_pkg::OFS_FAST_STATUS: decode = REG_FAST_STATUS;
      intc_pkg::OFS_FAST_RAW: decode = REG_FAST_RAW;
      intc_pkg::OFS_FAST_MASK: decode = REG_FAST_MASK;
      intc_pkg::OFS_FAST_CLEAR: decode = REG_FAST_CLEAR;
      intc_pkg::OFS_EVENT_STATUS: decode = REG_EVENT_STATUS;
      intc_pkg::OFS_EVENT_MASK: decode = REG_EVENT_MASK;
      default: decode = REG_NONE;
    endcase
  endfunction

  function automatic logic [intc_pkg::DATA_W-1:0] strobe_bits(input logic [3:0] strb);
    strobe_bits = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Write channel capture
  logic aw_have_q;
  logic [intc_pkg::ADDR_W-1:0] aw_addr_q;
  logic w_have_q;
  logic [intc_pkg::DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic write_fire;
  reg_sel_e wsel;
  logic [intc_pkg::DATA_W-1:0] wbits;

  // Read channel
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [intc_pkg::DATA_W-1:0] rdata_q;
  logic [intc_pkg::DATA_W-1:0] rdata_d;
  reg_sel_e rsel;

  // Controller state
  logic [WIDTH-1:0] normal_mask_q;
  logic [WIDTH-1:0] normal_mask_d;
  logic [WIDTH-1:0] fast_mask_q;
  logic [WIDTH-1:0] fast_mask_d;
  logic [intc_pkg::DATA_W-1:0] soft_ctrl_q;
  logic [WIDTH-1:0] normal_src;
  logic [WIDTH-1:0] fast_src;
  logic [WIDTH-1:0] normal_force;
  logic [WIDTH-1:0] fast_force;
  logic [WIDTH-1:0] normal_raw;
  logic [WIDTH-1:0] normal_status;
  logic [WIDTH-1:0] fast_raw;
  logic [WIDTH-1:0] fast_status;
  logic normal_req_q;
  logic fast_req_q;
  logic normal_req_prev_q;
  logic fast_req_prev_q;
  logic [intc_pkg::EVT_W-1:0] event_pulse;
  logic [intc_pkg::EVT_W-1:0] event_status;
  logic [intc_pkg::EVT_W-1:0] event_mask;

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Address and data may arrive in either order; each is held until both exist
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (write_fire) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (write_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Only one response outstanding, so the commit waits for bvalid to drain
  assign write_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wsel = decode(aw_addr_q);
  assign wbits = w_data_q & strobe_bits(w_strb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= intc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (write_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= (wsel == REG_NONE) ? intc_pkg::RESP_SLVERR : intc_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Mask update: enable writes only set, clear writes only clear; each path's
  // enable write also removes the same source from the other path
  always_comb begin
    normal_mask_d = normal_mask_q;
    fast_mask_d = fast_mask_q;
    if (write_fire) begin
      case (wsel)
        REG_NORMAL_MASK: begin
          normal_mask_d = normal_mask_q | wbits[WIDTH-1:0]; // see R5 see R6
          fast_mask_d = fast_mask_q & ~wbits[WIDTH-1:0]; // see R11
        end
        REG_NORMAL_CLEAR: begin
          normal_mask_d = normal_mask_q & ~wbits[WIDTH-1:0]; // see R7 see R12
        end
        REG_FAST_MASK: begin
          fast_mask_d = fast_mask_q | wbits[WIDTH-1:0]; // see R8
          normal_mask_d = normal_mask_q & ~wbits[WIDTH-1:0]; // see R10
        end
        REG_FAST_CLEAR: begin
          fast_mask_d = fast_mask_q & ~wbits[WIDTH-1:0]; // see R8 see R12
        end
        default: begin
          // Normal and fast status and raw registers are read-only; the write is dropped
          normal_mask_d = normal_mask_q; // see R15
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      normal_mask_q <= intc_pkg::RST_MASK[WIDTH-1:0]; // see R15
      fast_mask_q <= intc_pkg::RST_MASK[WIDTH-1:0]; // see R15
    end else if (ce) begin
      normal_mask_q <= normal_mask_d;
      fast_mask_q <= fast_mask_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_ctrl_q <= intc_pkg::RST_SOFT_CTRL;
    end else if (ce && write_fire && wsel == REG_SOFT_CTRL) begin
      soft_ctrl_q <= (soft_ctrl_q & ~strobe_bits(w_strb_q))
                   | (wbits & intc_pkg::SOFT_CTRL_USED);
    end
  end

  // Source assembly; bits 0 and 1 of the lines are replaced by internal sources.
  // The fast request feeds back through a register, which breaks the loop.
  always_comb begin
    normal_src = src_lines;
    fast_src = src_lines;
    normal_force = '0;
    fast_force = '0;
    normal_src[intc_pkg::FAST_SRC_BIT] = fast_req_q; // see R9
    fast_src[intc_pkg::FAST_SRC_BIT] = fast_req_q; // see R9
    normal_src[intc_pkg::SOFT_SRC_BIT] = soft_ctrl_q[intc_pkg::SOFT_NORMAL_BIT]; // see R13
    fast_src[intc_pkg::SOFT_SRC_BIT] = soft_ctrl_q[intc_pkg::SOFT_FAST_BIT]; // see R14
    normal_force[intc_pkg::SOFT_SRC_BIT] = 1'b1; // see R13
    fast_force[intc_pkg::SOFT_SRC_BIT] = 1'b1; // see R14
  end

  request_path #(
    .WIDTH(WIDTH)
  ) u_normal (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .src_lines(normal_src),
    .enable_mask(normal_mask_q),
    .force_mask(normal_force),
    .raw_q(normal_raw),
    .status_q(normal_status),
    .request_q(normal_req_q)
  );

  request_path #(
    .WIDTH(WIDTH)
  ) u_fast (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .src_lines(fast_src),
    .enable_mask(fast_mask_q),
    .force_mask(fast_force),
    .raw_q(fast_raw),
    .status_q(fast_status),
    .request_q(fast_req_q)
  );

  assign normal_request = normal_req_q; // see R1
  assign fast_request = fast_req_q; // see R9

  // Rising edges of each request are recorded as events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      normal_req_prev_q <= 1'b0;
      fast_req_prev_q <= 1'b0;
    end else if (ce) begin
      normal_req_prev_q <= normal_req_q;
      fast_req_prev_q <= fast_req_q;
    end
  end

  always_comb begin
    event_pulse = intc_pkg::RST_EVENT;
    event_pulse[intc_pkg::EVT_NORMAL_BIT] = normal_req_q && !normal_req_prev_q;
    event_pulse[intc_pkg::EVT_FAST_BIT] = fast_req_q && !fast_req_prev_q;
  end

  event_flags #(
    .WIDTH(intc_pkg::EVT_W)
  ) u_events (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .event_pulse(event_pulse),
    .status_clear_en(write_fire && wsel == REG_EVENT_STATUS),
    .mask_write_en(write_fire && wsel == REG_EVENT_MASK),
    .write_bits(wbits[intc_pkg::EVT_W-1:0]),
    .status_q(event_status),
    .mask_q(event_mask),
    .irq(irq)
  );

  // Read data; clear registers read as zero
  assign rsel = decode(s_axi_araddr);

  always_comb begin
    rdata_d = '0;
    case (rsel)
      REG_NORMAL_STATUS: rdata_d[WIDTH-1:0] = normal_status; // see R2 see R3
      REG_NORMAL_RAW: rdata_d[WIDTH-1:0] = normal_raw; // see R4
      REG_NORMAL_MASK: rdata_d[WIDTH-1:0] = normal_mask_q;
      REG_SOFT_CTRL: rdata_d = soft_ctrl_q;
      REG_FAST_STATUS: rdata_d[WIDTH-1:0] = fast_status; // see R8
      REG_FAST_RAW: rdata_d[WIDTH-1:0] = fast_raw; // see R8
      REG_FAST_MASK: rdata_d[WIDTH-1:0] = fast_mask_q;
      REG_EVENT_STATUS: rdata_d[intc_pkg::EVT_W-1:0] = event_status;
      REG_EVENT_MASK: rdata_d[intc_pkg::EVT_W-1:0] = event_mask;
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= intc_pkg::RESP_OKAY;
      rdata_q <= '0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q <= rdata_d;
        rresp_q <= (rsel == REG_NONE) ? intc_pkg::RESP_SLVERR : intc_pkg::RESP_OKAY;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* tb/intc_chk.sv */
// Port checker for the two-level interrupt controller.
// Assumes one clock aclk, a synchronous low reset and ce held high by the bench except in its freeze test.
`default_nettype none

module intc_chk #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [intc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [intc_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic normal_request,
  input wire logic fast_request,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic wrote_q;
  logic ar_hs;
  logic aw_w_hs;
  assign ar_hs = ce && s_axi_arvalid && s_axi_arready;
  assign aw_w_hs = ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  // Only a write can enable a source, so quiet requests are promised until the first one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrote_q <= 1'b0;
    end else if (ce && s_axi_awvalid && s_axi_awready) begin
      wrote_q <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_quiet:
    assert property (!$past(aresetn) |-> !normal_request && !fast_request && !irq)
    else $error("Outputs active after reset");
  chk_idle_quiet:
    assert property (!wrote_q |-> !normal_request && !fast_request)
    else $error("Request before any enable");
  chk_clear_reads:
    assert property (ar_hs && s_axi_araddr == intc_pkg::OFS_NORMAL_CLEAR |=>
      s_axi_rdata == 32'h0 && s_axi_rresp == intc_pkg::RESP_OKAY)
    else $error("Clear register read not zero");
  chk_unmapped_read:
    assert property (ar_hs && s_axi_araddr[31:12] != 20'hFFFF0 |=>
      s_axi_rresp == intc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("Unmapped read not refused");
  chk_read_answer:
    assert property (ar_hs |=> s_axi_rvalid)
    else $error("Read answer late");
  chk_write_answer:
    assert property (aw_w_hs && !s_axi_bvalid |-> ##[1:2] s_axi_bvalid)
    else $error("Write answer late");
  chk_b_holds:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped");
  chk_r_holds:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped");
  chk_ar_blocked:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Address taken with read pending");

  cover property ($rose(normal_request));
  cover property ($rose(fast_request));
  cover property ($rose(irq));
  cover property (s_axi_bvalid && s_axi_bresp == intc_pkg::RESP_SLVERR);
endmodule

bind dual_level_interrupt_controller intc_chk #(.WIDTH(WIDTH)) u_chk (.*);

`default_nettype wire

/* tb/core_model.sv */
// Behavioural processor core taking the normal and fast request levels.
// Assumes both levels are synchronous to aclk.
`default_nettype none

module core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic normal_request,
  input wire logic fast_request,
  output int normal_entries,
  output int fast_entries
);
  timeunit 1ns;
  timeprecision 100ps;
  logic in_normal_q;
  logic in_fast_q;

  // The fast level pre-empts the normal one, so a tie enters fast mode only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_normal_q <= 1'b0;
      in_fast_q <= 1'b0;
      normal_entries <= 0;
      fast_entries <= 0;
    end else begin
      in_fast_q <= fast_request;
      in_normal_q <= normal_request && !fast_request;
      if (fast_request && !in_fast_q) fast_entries <= fast_entries + 1;
      if (normal_request && !fast_request && !in_normal_q) normal_entries <= normal_entries + 1;
    end
  end
endmodule

`default_nettype wire

/* tb/dual_level_interrupt_controller_bench.sv */
// Self-checking bench for the two-level interrupt controller.
// Assumes the bench is the only bus master and the core model watches the requests.
`default_nettype none

module dual_level_interrupt_controller_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [31:0] src_lines = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic normal_request, fast_request, irq;
  int normal_entries, fast_entries;
  int n_mismatch = 0;
  int checked = 0;

  dual_level_interrupt_controller #(.WIDTH(32)) dut (.*);
  core_model core (.aclk, .aresetn, .normal_request, .fast_request,
    .normal_entries, .fast_entries);

  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic bad(input string what, input logic [31:0] g, input logic [31:0] e);
    n_mismatch++;
    $display("ERROR %0t: %s got %h want %h", $time, what, g, e);
  endtask

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) bad("word", g, e);
  endtask

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    checked++;
    if (g !== e) bad("resp", 32'(g), 32'(e));
  endtask

  task automatic chk_line(input logic g, input logic e);
    checked++;
    if (g !== e) bad("line", 32'(g), 32'(e));
  endtask

  // Ready is looked at on the falling edge, where it equals what the rising edge samples
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
    input logic [1:0] er = intc_pkg::RESP_OKAY);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    for (int n = 0; n < 20 && !tb; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    if (!tb) begin
      bad("write timeout", a, d);
      test_done();
    end else begin
      chk_resp(r, er);
    end
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] ed,
    input logic [1:0] er = intc_pkg::RESP_OKAY);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    for (int n = 0; n < 20 && !tr; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    if (!tr) begin
      bad("read timeout", a, ed);
      test_done();
    end else begin
      chk_word(d, ed);
      chk_resp(r, er);
    end
  endtask

  task automatic src(input logic [31:0] v);
    @(posedge aclk);
    src_lines <= v;
  endtask

  // Fast feedback into bit 0 takes one extra edge, so three edges cover every path
  task automatic lines(input logic en, input logic ef, input logic ei);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk_line(normal_request, en);
    chk_line(fast_request, ef);
    chk_line(irq, ei);
  endtask

  task automatic ended(input string name);
    $display("Test %s finished at %0t", name, $time);
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(intc_pkg::OFS_NORMAL_MASK, 32'h0);
    rd(intc_pkg::OFS_FAST_MASK, 32'h0);
    wr(intc_pkg::OFS_NORMAL_STATUS, 32'hFFFFFFFF);
    wr(intc_pkg::OFS_NORMAL_RAW, 32'hFFFFFFFF);
    src(32'h00000020);
    lines(1'b0, 1'b0, 1'b0);
    rd(intc_pkg::OFS_NORMAL_RAW, 32'h20);
    rd(intc_pkg::OFS_NORMAL_STATUS, 32'h0);
    wr(32'h40, 32'hFFFFFFFF, intc_pkg::RESP_SLVERR);
    rd(32'h40, 32'h0, intc_pkg::RESP_SLVERR);
    ended("reset");
    wr(intc_pkg::OFS_NORMAL_MASK, 32'h60);
    lines(1'b1, 1'b0, 1'b0);
    rd(intc_pkg::OFS_NORMAL_STATUS, 32'h20);
    wr(intc_pkg::OFS_NORMAL_MASK, 32'h0);
    rd(intc_pkg::OFS_NORMAL_MASK, 32'h60);
    rd(intc_pkg::OFS_NORMAL_CLEAR, 32'h0);
    wr(intc_pkg::OFS_NORMAL_CLEAR, 32'h20);
    rd(intc_pkg::OFS_NORMAL_MASK, 32'h40);
    lines(1'b0, 1'b0, 1'b0);
    rd(intc_pkg::OFS_NORMAL_RAW, 32'h20);
    rd(intc_pkg::OFS_EVENT_STATUS, 32'h1);
    wr(intc_pkg::OFS_EVENT_MASK, 32'h3);
    lines(1'b0, 1'b0, 1'b1);
    wr(intc_pkg::OFS_EVENT_STATUS, 32'h1);
    lines(1'b0, 1'b0, 1'b0);
    ended("normal");
    wr(intc_pkg::OFS_NORMAL_MASK, 32'h20);
    wr(intc_pkg::OFS_FAST_MASK, 32'h20);
    rd(intc_pkg::OFS_NORMAL_MASK, 32'h40);
    lines(1'b0, 1'b1, 1'b1);
    rd(intc_pkg::OFS_FAST_STATUS, 32'h20);
    rd(intc_pkg::OFS_NORMAL_RAW, 32'h21);
    wr(intc_pkg::OFS_NORMAL_MASK, 32'h1);
    lines(1'b1, 1'b1, 1'b1);
    wr(intc_pkg::OFS_FAST_CLEAR, 32'h20);
    lines(1'b0, 1'b0, 1'b1);
    wr(intc_pkg::OFS_NORMAL_CLEAR, 32'h41);
    wr(intc_pkg::OFS_FAST_MASK, 32'h40);
    wr(intc_pkg::OFS_NORMAL_MASK, 32'h40);
    rd(intc_pkg::OFS_FAST_MASK, 32'h0);
    wr(intc_pkg::OFS_NORMAL_CLEAR, 32'h40);
    rd(intc_pkg::OFS_NORMAL_MASK, 32'h0);
    rd(intc_pkg::OFS_EVENT_STATUS, 32'h3);
    wr(intc_pkg::OFS_EVENT_STATUS, 32'h3);
    lines(1'b0, 1'b0, 1'b0);
    ended("fast");
    wr(intc_pkg::OFS_SOFT_CTRL, 32'h2);
    lines(1'b1, 1'b0, 1'b1);
    rd(intc_pkg::OFS_NORMAL_STATUS, 32'h2);
    rd(intc_pkg::OFS_NORMAL_RAW, 32'h22);
    wr(intc_pkg::OFS_SOFT_CTRL, 32'h4);
    lines(1'b0, 1'b1, 1'b1);
    rd(intc_pkg::OFS_FAST_STATUS, 32'h2);
    rd(intc_pkg::OFS_FAST_RAW, 32'h23);
    s_axi_wstrb <= 4'hE;
    wr(intc_pkg::OFS_SOFT_CTRL, 32'h0);
    s_axi_wstrb <= 4'hF;
    rd(intc_pkg::OFS_SOFT_CTRL, 32'h4);
    wr(intc_pkg::OFS_SOFT_CTRL, 32'h0);
    lines(1'b0, 1'b0, 1'b1);
    ended("software");
    // A frozen block must hold its request although the source has dropped
    wr(intc_pkg::OFS_NORMAL_MASK, 32'h20);
    ce <= 1'b0;
    src(32'h0);
    lines(1'b1, 1'b0, 1'b1);
    @(posedge aclk);
    ce <= 1'b1;
    lines(1'b0, 1'b0, 1'b1);
    chk_word(32'(fast_entries), 32'h2);
    chk_word(32'(normal_entries), 32'h5);
    ended("freeze");
    test_done();
  end
endmodule

`default_nettype wire
